// >>> verilog/flash_ctl_pkg.sv
// flash_ctl_pkg: opcodes, status layout, geometry and timing for the flash control block
// assumes: a single 250 MHz system clock; serial link signals sampled by that clock
package flash_ctl_pkg;
   // opcodes
   localparam logic [7:0] OP_LATCH_SET = 8'h06;
   localparam logic [7:0] OP_LATCH_CLR = 8'h04;
   localparam logic [7:0] OP_STAT_RD = 8'h05;
   localparam logic [7:0] OP_STAT_WR = 8'h01;
   localparam logic [7:0] OP_PAGE_WR = 8'h02;
   localparam logic [7:0] OP_SECT_CLR = 8'h20;
   localparam logic [7:0] OP_BLK_CLR = 8'hd8;
   localparam logic [7:0] OP_ALL_CLR_A = 8'hc7;
   localparam logic [7:0] OP_ALL_CLR_B = 8'h60;
   localparam logic [7:0] OP_SLEEP = 8'hb9;
   localparam logic [7:0] OP_WAKE = 8'hab;
   localparam logic [7:0] OP_QUAD_ENTRY = 8'h38;
   localparam logic [7:0] OP_DUAL_OUT = 8'h3b;
   localparam logic [7:0] OP_DUAL_IO = 8'hbb;
   localparam logic [7:0] OP_QUAD_IO = 8'heb;
   localparam logic [7:0] OP_OTP_ENTER = 8'h3a;
   // status bit positions
   localparam int ST_BUSY = 0;
   localparam int ST_LATCH = 1;
   localparam int ST_GUARD_LO = 2;
   localparam int ST_GUARD_HI = 5;
   localparam int ST_PIN_OFF = 6;
   localparam int ST_LOCK = 7;
   localparam logic [7:0] STATUS_RESET = 8'h00;
   // geometry: 64 blocks
   localparam int BLOCK_BITS = 6;
   localparam int ADDR_BITS = 24;
   localparam int BLOCK_MSB = 21;
   localparam int PAGE_BYTES = 256;
   // cycle times in microseconds, cycles at 250 MHz
   localparam int CLK_MHZ = 250;
   localparam int T_STATUS_US = 10;
   localparam int T_PAGE_US = 1300;
   localparam int T_SECT_US = 90000;
   localparam int T_BLOCK_US = 500000;
   localparam int T_CHIP_US = 25000000;
   localparam logic [7:0] FLAG_ONES = 8'hff;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_BUSY_RUN = 2'b01,
      ST_SLEEP = 2'b11
   } power_state_t;
   typedef struct packed {
      logic sclk;
      logic sel_n;
      logic [3:0] io;
   } link_in_t;
   typedef struct packed {
      logic [3:0] out;
      logic [3:0] oe;
   } link_out_t;
endpackage : flash_ctl_pkg

// >>> verilog/guard_decode.sv
// guard_decode: maps the four guard bits and an address to a protected flag
// assumes: 64 blocks, address bits 21..16 give the block index
`timescale 1ns/1ns
module guard_decode (
   input wire logic [3:0] i_guard,
   input wire logic [23:0] i_addr,
   output logic o_protected
);
   import flash_ctl_pkg::*;
   logic [BLOCK_BITS-1:0] blk;
   logic [BLOCK_BITS:0] count;
   // ---------------------------------------------------------------
   // protected block count and direction
   // ---------------------------------------------------------------
   // count per code
   always_comb begin
      blk = i_addr[BLOCK_MSB -: BLOCK_BITS];
      case (i_guard[2:0])
         3'h1: count = 7'h3f;
         3'h2: count = 7'h3e;
         3'h3: count = 7'h3c;
         3'h4: count = 7'h38;
         3'h5: count = 7'h30;
         3'h6: count = 7'h20;
         3'h7: count = 7'h40;
         default: count = 7'h00;
      endcase
      if (count == 7'h00) begin
         o_protected = 1'b0;
      end else if (i_guard[3]) begin
         // counted down from the top block
         o_protected = ({1'b0, blk} >= (7'h40 - count));
      end else begin
         o_protected = ({1'b0, blk} < count);
      end
   end
endmodule : guard_decode

// >>> verilog/flash_ctl.sv
// flash_ctl: serial flash command front end with protection and status
// assumes: link pins are asynchronous, sampled by i_sys_clk after two flops;
// the array itself lives outside; this block issues program/erase strobes.
`timescale 1ns/1ns
module flash_ctl #(
   parameter int T_PAGE_CYC = flash_ctl_pkg::T_PAGE_US * flash_ctl_pkg::CLK_MHZ,
   parameter int T_SECT_CYC = flash_ctl_pkg::T_SECT_US * flash_ctl_pkg::CLK_MHZ,
   parameter int T_BLOCK_CYC = flash_ctl_pkg::T_BLOCK_US * flash_ctl_pkg::CLK_MHZ,
   // wider type: a whole-array clear at full clock rate overflows an int
   parameter longint T_CHIP_CYC = longint'(flash_ctl_pkg::T_CHIP_US) * flash_ctl_pkg::CLK_MHZ,
   parameter int T_STATUS_CYC = flash_ctl_pkg::T_STATUS_US * flash_ctl_pkg::CLK_MHZ
) (
   input wire logic i_sys_clk,
   input wire logic i_reset_n,
   input wire flash_ctl_pkg::link_in_t i_link,
   output flash_ctl_pkg::link_out_t o_link,
   input wire logic [7:0] i_array_data,
   output logic [23:0] o_array_addr,
   output logic [7:0] o_array_wdata,
   output logic o_array_wr,
   output logic o_sect_clr,
   output logic o_blk_clr,
   output logic o_chip_clr,
   output logic o_busy,
   output logic o_sleep
);
   import flash_ctl_pkg::*;
   // ---------------------------------------------------------------
   // reset and pin synchronisers
   // ---------------------------------------------------------------
   logic [1:0] rst_sync_r;
   logic rst_n;
   link_in_t meta_r, sync_r;
   logic sclk_d_r;
   always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         rst_sync_r <= 2'b00;
      end else begin
         rst_sync_r <= {rst_sync_r[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_r[1];
   // two flops on every link pin before use
   always_ff @(posedge i_sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_r <= '{sclk: 1'b0, sel_n: 1'b1, io: 4'h0};
         sync_r <= '{sclk: 1'b0, sel_n: 1'b1, io: 4'h0};
         sclk_d_r <= 1'b0;
      end else begin
         meta_r <= i_link;
         sync_r <= meta_r;
         sclk_d_r <= sync_r.sclk;
      end
   end
   logic sel, rise, fall, sel_d_r, sel_end;
   assign sel = !sync_r.sel_n;
   assign rise = sel && sync_r.sclk && !sclk_d_r;
   assign fall = sel && !sync_r.sclk && sclk_d_r;
   assign sel_end = sel_d_r && !sel;
   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   power_state_t pstate_r;
   logic [7:0] status_r;
   logic quad_mode_r, otp_mode_r;
   logic [39:0] cyc_cnt_r;
   logic [7:0] shift_r, opcode_r;
   logic [15:0] bitcnt_r;
   logic [23:0] addr_r;
   logic [7:0] out_r;
   logic [1:0] width_r;
   logic [3:0] oe_r;
   logic hw_guard, prot_hit, latch_ok, byte_done;
   logic [2:0] step;
   assign hw_guard = status_r[ST_LOCK] && !sync_r.io[2] && !status_r[ST_PIN_OFF];
   assign latch_ok = status_r[ST_LATCH];
   // four bits per edge in quad mode
   assign step = quad_mode_r ? 3'h4 : 3'h1;
   assign byte_done = rise && (bitcnt_r[2:0] + step[2:0] == 3'h0 || (quad_mode_r
      && bitcnt_r[2:0] == 3'h4));
   guard_decode u_guard (
      .i_guard(status_r[ST_GUARD_HI:ST_GUARD_LO]),
      .i_addr(addr_r),
      .o_protected(prot_hit)
   );
   // ---------------------------------------------------------------
   // input shifter
   // ---------------------------------------------------------------
   // msb first from first rise
   always_ff @(posedge i_sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         shift_r <= 8'h00;
         bitcnt_r <= 16'h0000;
         sel_d_r <= 1'b0;
      end else begin
         sel_d_r <= sel;
         if (!sel) begin
            bitcnt_r <= 16'h0000;
         end else if (rise) begin
            shift_r <= quad_mode_r ? {shift_r[3:0], sync_r.io} : {shift_r[6:0], sync_r.io[0]};
            bitcnt_r <= bitcnt_r + {13'h0000, step};
         end
      end
   end
   logic [7:0] in_byte;
   assign in_byte = quad_mode_r ? {shift_r[3:0], sync_r.io} : {shift_r[6:0], sync_r.io[0]};
   // ---------------------------------------------------------------
   // command decode and address capture
   // ---------------------------------------------------------------
   logic [15:0] nbytes;
   assign nbytes = bitcnt_r >> 3;
   logic [7:0] wdata_r;
   logic wr_pulse_r;
   always_ff @(posedge i_sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         opcode_r <= 8'h00;
         addr_r <= 24'h000000;
         wdata_r <= 8'h00;
         wr_pulse_r <= 1'b0;
      end else begin
         wr_pulse_r <= 1'b0;
         if (byte_done) begin
            if (nbytes == 16'h0000) begin
               opcode_r <= in_byte;
            end else if (nbytes < 16'h0004) begin
               addr_r <= {addr_r[15:0], in_byte};
            end else if (opcode_r == OP_PAGE_WR && pstate_r == ST_IDLE && latch_ok
                  && !prot_hit && !(otp_mode_r && status_r[ST_LOCK])) begin
               // ones to zeros, wrap within page
               wdata_r <= in_byte & i_array_data;
               wr_pulse_r <= 1'b1;
            end
         end else if (wr_pulse_r) begin
            // step after the pulse so address and data agree while it stands
            addr_r[7:0] <= addr_r[7:0] + 8'h01;
         end
      end
   end
   assign o_array_wdata = wdata_r;
   assign o_array_wr = wr_pulse_r;
   assign o_array_addr = addr_r;
   // ---------------------------------------------------------------
   // end of command: execute on select rising
   // ---------------------------------------------------------------
   logic whole;
   assign whole = (bitcnt_r[2:0] == 3'h0);
   logic sc_r, bc_r, cc_r;
   logic [7:0] status_wr_r;
   always_ff @(posedge i_sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         pstate_r <= ST_IDLE;
         status_r <= STATUS_RESET;
         quad_mode_r <= 1'b0;
         otp_mode_r <= 1'b0;
         cyc_cnt_r <= 40'h0;
         sc_r <= 1'b0;
         bc_r <= 1'b0;
         cc_r <= 1'b0;
         status_wr_r <= 8'h00;
      end else begin
         sc_r <= 1'b0;
         bc_r <= 1'b0;
         cc_r <= 1'b0;
         if (byte_done && nbytes == 16'h0001 && opcode_r == OP_STAT_WR) begin
            status_wr_r <= in_byte;
         end
         case (pstate_r)
            ST_BUSY_RUN: begin
               if (cyc_cnt_r <= 40'h1) begin
                  pstate_r <= ST_IDLE;
                  status_r[ST_BUSY] <= 1'b0;
               end else begin
                  cyc_cnt_r <= cyc_cnt_r - 40'h1;
               end
            end
            ST_SLEEP: begin
               if (sel_end && whole && opcode_r == OP_WAKE && bitcnt_r != 16'h0) begin
                  pstate_r <= ST_IDLE;
               end
            end
            default: begin
               if (sel_end && whole && bitcnt_r != 16'h0) begin
                  case (opcode_r)
                     OP_LATCH_SET: if (nbytes == 16'h1) status_r[ST_LATCH] <= 1'b1;
                     OP_LATCH_CLR: if (nbytes == 16'h1) begin
                        status_r[ST_LATCH] <= 1'b0;
                        otp_mode_r <= 1'b0;
                     end
                     OP_OTP_ENTER: if (nbytes == 16'h1) otp_mode_r <= 1'b1;
                     OP_QUAD_ENTRY: if (nbytes == 16'h1) quad_mode_r <= 1'b1;
                     OP_SLEEP: if (nbytes == 16'h1) pstate_r <= ST_SLEEP;
                     OP_STAT_WR: begin
                        if (latch_ok && nbytes == 16'h2) begin
                           status_r[ST_LATCH] <= 1'b0;
                           status_r[ST_BUSY] <= 1'b1;
                           pstate_r <= ST_BUSY_RUN;
                           cyc_cnt_r <= 40'(T_STATUS_CYC);
                           if (otp_mode_r) begin
                              status_r[ST_LOCK] <= 1'b1;
                           end else if (!hw_guard) begin
                              status_r[7:2] <= status_wr_r[7:2];
                           end else begin
                              status_r[ST_PIN_OFF] <= status_wr_r[ST_PIN_OFF];
                           end
                        end
                     end
                     OP_PAGE_WR: begin
                        if (latch_ok && nbytes >= 16'h5) begin
                           status_r[ST_LATCH] <= 1'b0;
                           status_r[ST_BUSY] <= 1'b1;
                           pstate_r <= ST_BUSY_RUN;
                           cyc_cnt_r <= 40'(T_PAGE_CYC);
                        end
                     end
                     OP_SECT_CLR, OP_BLK_CLR: begin
                        if (latch_ok && nbytes == 16'h4) begin
                           status_r[ST_LATCH] <= 1'b0;
                           if (!prot_hit && !(otp_mode_r && status_r[ST_LOCK])) begin
                              status_r[ST_BUSY] <= 1'b1;
                              pstate_r <= ST_BUSY_RUN;
                              sc_r <= (opcode_r == OP_SECT_CLR);
                              bc_r <= (opcode_r == OP_BLK_CLR);
                              cyc_cnt_r <= (opcode_r == OP_SECT_CLR) ?
                                 40'(T_SECT_CYC) : 40'(T_BLOCK_CYC);
                           end
                        end
                     end
                     OP_ALL_CLR_A, OP_ALL_CLR_B: begin
                        if (latch_ok && nbytes == 16'h1) begin
                           status_r[ST_LATCH] <= 1'b0;
                           // any guarded area blocks a whole clear
                           if (status_r[ST_GUARD_LO+2:ST_GUARD_LO] == 3'h0) begin
                              status_r[ST_BUSY] <= 1'b1;
                              pstate_r <= ST_BUSY_RUN;
                              cc_r <= 1'b1;
                              cyc_cnt_r <= 40'(T_CHIP_CYC);
                           end
                        end
                     end
                     default: ;
                  endcase
               end
            end
         endcase
      end
   end
   assign o_sect_clr = sc_r;
   assign o_blk_clr = bc_r;
   assign o_chip_clr = cc_r;
   assign o_busy = status_r[ST_BUSY];
   assign o_sleep = (pstate_r == ST_SLEEP);
   // ---------------------------------------------------------------
   // output shifter and pin direction
   // ---------------------------------------------------------------
   // widen on read opcodes after the opcode byte
   always_ff @(posedge i_sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         out_r <= 8'h00;
         width_r <= 2'h0;
         oe_r <= 4'h0;
      end else if (!sel) begin
         oe_r <= 4'h0;
         width_r <= 2'h0;
      end else if (fall && nbytes >= 16'h1 && pstate_r != ST_SLEEP) begin
         // shift out on falling link edge
         if (bitcnt_r[2:0] == 3'h0) begin
            out_r <= (opcode_r == OP_STAT_RD) ? status_r : i_array_data;
         end else begin
            out_r <= {out_r[6:0], 1'b0};
         end
         if (opcode_r == OP_DUAL_OUT || opcode_r == OP_DUAL_IO) begin
            width_r <= 2'h1;
            oe_r <= (nbytes >= 16'h4) ? 4'h3 : 4'h0;
         end else if (opcode_r == OP_QUAD_IO || quad_mode_r) begin
            width_r <= 2'h2;
            oe_r <= (nbytes >= 16'h4 || opcode_r == OP_STAT_RD) ? 4'hf : 4'h0;
         end else begin
            width_r <= 2'h0;
            oe_r <= (opcode_r == OP_STAT_RD || nbytes >= 16'h4) ? 4'h2 : 4'h0;
         end
      end
   end
   always_comb begin
      o_link.oe = oe_r;
      case (width_r)
         2'h1: o_link.out = {2'b00, out_r[7:6]};
         2'h2: o_link.out = out_r[7:4];
         default: o_link.out = {2'b00, out_r[7], 1'b0};
      endcase
   end
endmodule : flash_ctl

// >>> bench/flash_ctl_sva.sv
// flash_ctl_sva: port checks for flash_ctl
// assumes: bound to flash_ctl, sees only its ports
`timescale 1ns/1ns
module flash_ctl_sva
   import flash_ctl_pkg::*;
#(
   parameter int T_PAGE_CYC = 20, parameter int T_SECT_CYC = 20,
   parameter int T_BLOCK_CYC = 20, parameter int T_CHIP_CYC = 20,
   parameter int T_STATUS_CYC = 20
) (
   input wire logic i_sys_clk,
   input wire logic i_reset_n,
   input wire flash_ctl_pkg::link_in_t i_link,
   input wire flash_ctl_pkg::link_out_t o_link,
   input wire logic [7:0] i_array_data,
   input wire logic [7:0] o_array_wdata,
   input wire logic o_array_wr,
   input wire logic o_sect_clr,
   input wire logic o_blk_clr,
   input wire logic o_chip_clr,
   input wire logic o_busy,
   input wire logic o_sleep
);
   // shorter of the status and page cycles bounds the busy length from below
   localparam int T_MIN = (T_STATUS_CYC < T_PAGE_CYC) ? T_STATUS_CYC : T_PAGE_CYC;
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_reset_n);
   logic any_clr;
   logic [31:0] busy_cnt_r;
   assign any_clr = o_sect_clr | o_blk_clr | o_chip_clr;
   // length of the current busy stretch
   always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
      if (!i_reset_n) busy_cnt_r <= '0;
      else if (o_busy) busy_cnt_r <= busy_cnt_r + 32'd1;
      else busy_cnt_r <= '0;
   end
   property p_clr_busy;
      any_clr |-> ##[0:3] o_busy;
   endproperty
   a_clr_busy: assert property (p_clr_busy) else $error("erase without busy");
   property p_clr_idle;
      any_clr |-> !$past(o_busy);
   endproperty
   a_clr_idle: assert property (p_clr_idle) else $error("erase started while busy");
   property p_clr_one;
      any_clr |-> $onehot0({o_sect_clr, o_blk_clr, o_chip_clr}) ##1 !any_clr;
   endproperty
   a_clr_one: assert property (p_clr_one) else $error("erase pulse malformed");
   property p_prog_down;
      o_array_wr |-> (o_array_wdata & ~i_array_data) == 8'h00;
   endproperty
   a_prog_down: assert property (p_prog_down) else $error("program raised a bit");
   property p_frame_end;
      (any_clr || $rose(o_busy)) |-> i_link.sel_n && $past(i_link.sel_n);
   endproperty
   a_frame_end: assert property (p_frame_end) else $error("cycle began inside frame");
   property p_sleep_quiet;
      o_sleep |-> !o_array_wr && !any_clr && !o_busy;
   endproperty
   a_sleep_quiet: assert property (p_sleep_quiet) else $error("activity in sleep");
   property p_busy_min;
      $fell(o_busy) |-> busy_cnt_r + 32'd2 >= T_MIN;
   endproperty
   a_busy_min: assert property (p_busy_min) else $error("busy too short");
   property p_oe_idle;
      i_link.sel_n [*6] |-> o_link.oe == 4'h0;
   endproperty
   a_oe_idle: assert property (p_oe_idle) else $error("io driven while idle");
endmodule : flash_ctl_sva

// >>> bench/spi_master_model.sv
// spi_master_model: link master that runs one frame per call
// assumes: driven from the bench; steps on falling edges of i_clk
`timescale 1ns/1ns
module spi_master_model
   import flash_ctl_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_mode3,
   input wire logic i_protect_n,
   input wire flash_ctl_pkg::link_out_t i_dev,
   output flash_ctl_pkg::link_in_t o_pins
);
   logic sclk = 1'b0;
   logic sel_n = 1'b1;
   logic d0 = 1'b0;
   logic [7:0] rd_sh = 8'h00;
   logic [3:0] drv;
   // device enable wins on a line; line 1 shows a changing pattern otherwise
   assign drv = {1'b1, i_protect_n, ~d0, d0};
   assign o_pins = '{sclk: sclk, sel_n: sel_n, io: (i_dev.oe & i_dev.out) | (~i_dev.oe & drv)};
   // half a link period: 24 ns, 48 ns per bit
   task automatic half();
      repeat (6) @(negedge i_clk);
   endtask : half
   task automatic frame(input logic [39:0] w, input int nbits, output logic [7:0] rd);
      sclk = i_mode3;
      half();
      sel_n = 1'b0;
      half();
      sclk = 1'b0;
      for (int i = 0; i < nbits; i++) begin
         d0 = w[39 - i];
         half();
         sclk = 1'b1;
         rd_sh = {rd_sh[6:0], o_pins.io[1]};
         half();
         if (!(i_mode3 && i == nbits - 1)) sclk = 1'b0;
      end
      half();
      sel_n = 1'b1;
      // released line: inverse of last bit
      d0 = ~d0;
      rd = rd_sh;
      half();
   endtask : frame
endmodule : spi_master_model

// >>> bench/serial_flash_protect_and_status_test.sv
// serial_flash_protect_and_status_test: directed checks of flash_ctl
// assumes: spi_master_model drives the link; array bytes modelled here
`timescale 1ns/1ns
module serial_flash_protect_and_status_test;
   import flash_ctl_pkg::*;
   localparam int T_CYC = 400;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic mode3 = 1'b0;
   logic prot_n = 1'b1;
   link_in_t link_in;
   link_out_t link_out;
   logic [7:0] arr_data, wdata, last_wdata, rd;
   logic [23:0] arr_addr, pulse_addr;
   logic wr, sect_clr, blk_clr, chip_clr, busy, sleep;
   int errors = 0;
   int num_checks = 0;
   int n_wr = 0;
   int n_clr = 0;
   always #2 clk = ~clk;
   // array byte follows address so the programmed and shows
   assign arr_data = arr_addr[7:0] ^ 8'h5a;
   flash_ctl #(.T_PAGE_CYC(T_CYC), .T_SECT_CYC(T_CYC), .T_BLOCK_CYC(T_CYC),
      .T_CHIP_CYC(T_CYC), .T_STATUS_CYC(T_CYC)) uut (.i_sys_clk(clk), .i_reset_n(reset_n),
      .i_link(link_in), .o_link(link_out), .i_array_data(arr_data), .o_array_addr(arr_addr),
      .o_array_wdata(wdata), .o_array_wr(wr), .o_sect_clr(sect_clr), .o_blk_clr(blk_clr),
      .o_chip_clr(chip_clr), .o_busy(busy), .o_sleep(sleep));
   spi_master_model master (.i_clk(clk), .i_mode3(mode3), .i_protect_n(prot_n),
      .i_dev(link_out), .o_pins(link_in));
   // count pulses and keep what they carried
   always @(negedge clk) begin
      if (wr) begin
         n_wr++;
         last_wdata = wdata;
         pulse_addr = arr_addr;
      end
      if (sect_clr | blk_clr | chip_clr) begin
         n_clr++;
         pulse_addr = arr_addr;
      end
   end
   task automatic test_done();
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : test_done
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check
   task automatic cmd(input logic [39:0] w, input int nbits);
      master.frame(w, nbits, rd);
   endtask : cmd
   // bounded wait for the internal cycle to end
   task automatic wait_idle();
      int n;
      n = 0;
      while (busy !== 1'b0 && n < 4000) begin
         @(negedge clk);
         n++;
      end
      check(n < 4000, 1'b1);
      if (n >= 4000) test_done();
   endtask : wait_idle
   task automatic set_status(input logic [7:0] v);
      cmd({OP_LATCH_SET, 32'h0}, 8);
      cmd({OP_STAT_WR, v, 24'h0}, 16);
      wait_idle();
   endtask : set_status
   // latch then one erase; ok says whether it may run
   task automatic try_clr(input logic [31:0] w, input int nbits, input logic ok);
      int n0;
      n0 = n_clr;
      cmd({OP_LATCH_SET, 32'h0}, 8);
      cmd({w, 8'h00}, nbits);
      wait_idle();
      check(n_clr - n0, ok);
      if (ok && nbits == 32) check(pulse_addr, w[23:0]);
   endtask : try_clr
   task automatic t_latch();
      int n0;
      n0 = n_clr;
      master.frame({OP_STAT_RD, 32'h0}, 16, rd);
      check(rd, STATUS_RESET);
      cmd({OP_SECT_CLR, 24'h010000, 8'h0}, 32);
      cmd({OP_LATCH_SET, 32'h0}, 8);
      master.frame({OP_STAT_RD, 32'h0}, 16, rd);
      check(rd, 8'h02);
      cmd({OP_SECT_CLR, 24'h010000, 8'h0}, 33);
      cmd({OP_BLK_CLR, 16'h0100, 16'h0}, 24);
      check(n_clr - n0, 0);
      cmd({OP_LATCH_CLR, 32'h0}, 8);
      master.frame({OP_STAT_RD, 32'h0}, 16, rd);
      check(rd, 8'h00);
   endtask : t_latch
   task automatic t_erase_prog();
      int n0;
      n0 = n_wr;
      cmd({OP_LATCH_SET, 32'h0}, 8);
      cmd({OP_SECT_CLR, 24'h123000, 8'h0}, 32);
      master.frame({OP_STAT_RD, 32'h0}, 16, rd);
      check(rd[0], 1'b1);
      wait_idle();
      check(pulse_addr, 24'h123000);
      master.frame({OP_STAT_RD, 32'h0}, 16, rd);
      check(rd, 8'h00);
      cmd({OP_LATCH_SET, 32'h0}, 8);
      // data with a one where the old byte has a zero, so the and shows
      cmd({OP_PAGE_WR, 24'h0456a7, 8'h3e}, 40);
      wait_idle();
      check(n_wr - n0, 1);
      check(pulse_addr, 24'h0456a7);
      check(last_wdata, 8'h3e & (8'ha7 ^ 8'h5a));
      try_clr({OP_ALL_CLR_A, 24'h0}, 8, 1'b1);
      try_clr({OP_ALL_CLR_B, 24'h0}, 8, 1'b1);
   endtask : t_erase_prog
   task automatic t_guard();
      logic [7:0] gv [8] = '{8'h04, 8'h04, 8'h24, 8'h24, 8'h18, 8'h18, 8'h20, 8'h1c};
      logic [31:0] cv [8] = '{32'h203e0000, 32'hd83f0000, 32'h20000000, 32'hd8010000,
         32'h201f0000, 32'hd8200000, 32'h203f0000, 32'hd8200000};
      logic okv [8] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
      for (int i = 0; i < 8; i++) begin
         set_status(gv[i]);
         master.frame({OP_STAT_RD, 32'h0}, 16, rd);
         check(rd, gv[i]);
         try_clr(cv[i], 32, okv[i]);
      end
      set_status(8'h80);
      prot_n = 1'b0;
      set_status(8'h04);
      master.frame({OP_STAT_RD, 32'h0}, 16, rd);
      check(rd, 8'h80);
      prot_n = 1'b1;
      set_status(8'hc0);
      prot_n = 1'b0;
      set_status(8'h04);
      master.frame({OP_STAT_RD, 32'h0}, 16, rd);
      check(rd, 8'h04);
      prot_n = 1'b1;
      set_status(8'h00);
   endtask : t_guard
   // otp mode: status write sets the lock bit, then a sector erase is refused
   task automatic t_otp();
      cmd({OP_OTP_ENTER, 32'h0}, 8);
      set_status(8'h00);
      master.frame({OP_STAT_RD, 32'h0}, 16, rd);
      check(rd, 8'h80);
      try_clr({OP_SECT_CLR, 24'h001000}, 32, 1'b0);
      cmd({OP_LATCH_CLR, 32'h0}, 8);
      set_status(8'h00);
      master.frame({OP_STAT_RD, 32'h0}, 16, rd);
      check(rd, 8'h00);
   endtask : t_otp
   task automatic t_sleep_mode3();
      cmd({OP_SLEEP, 32'h0}, 8);
      check(sleep, 1'b1);
      cmd({OP_LATCH_SET, 32'h0}, 8);
      cmd({OP_WAKE, 32'h0}, 8);
      check(sleep, 1'b0);
      mode3 = 1'b1;
      master.frame({OP_STAT_RD, 32'h0}, 16, rd);
      check(rd, 8'h00);
      cmd({OP_LATCH_SET, 32'h0}, 8);
      master.frame({OP_STAT_RD, 32'h0}, 16, rd);
      check(rd, 8'h02);
      mode3 = 1'b0;
   endtask : t_sleep_mode3
   // reset, then the scenarios in turn
   initial begin
      repeat (5) @(negedge clk);
      reset_n = 1'b1;
      repeat (4) @(negedge clk);
      t_latch();
      t_erase_prog();
      t_guard();
      t_otp();
      t_sleep_mode3();
      test_done();
   end
endmodule : serial_flash_protect_and_status_test
bind flash_ctl flash_ctl_sva #(.T_PAGE_CYC(T_PAGE_CYC), .T_SECT_CYC(T_SECT_CYC),
   .T_BLOCK_CYC(T_BLOCK_CYC), .T_CHIP_CYC(T_CHIP_CYC), .T_STATUS_CYC(T_STATUS_CYC)) chk (
   .i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .i_link(i_link), .o_link(o_link),
   .i_array_data(i_array_data), .o_array_wdata(o_array_wdata), .o_array_wr(o_array_wr),
   .o_sect_clr(o_sect_clr), .o_blk_clr(o_blk_clr), .o_chip_clr(o_chip_clr),
   .o_busy(o_busy), .o_sleep(o_sleep));
